// ==== rtl/acc_top.sv ====
// Control and status logic for two analog comparators, AXI4-Lite slave.
// Assumes analog cores, pin driver and Timer1 sit outside this block.
`timescale 1ns/1ns
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Raw compare results from the analog cores, asynchronous
  input wire logic [ACC_NUM-1:0] core_compare_raw,
  // Timer1 clocks, raw and after its prescaler, plus prescaler in use
  input wire logic tmr1_src_clk,
  input wire logic tmr1_presc_clk,
  input wire logic tmr1_presc_used,
  // Analog controls per comparator
  output logic [ACC_NUM-1:0] core_power_on,
  output logic [ACC_NUM-1:0] core_speed_high,
  output logic [ACC_NUM-1:0] core_hysteresis_on,
  // One-hot input switches: pin, DAC, fixed, ground
  output logic [ACC_NUM-1:0][3:0] plus_route,
  // One-hot input switches: pin1, pin2, pin3, fixed
  output logic [ACC_NUM-1:0][3:0] minus_route,
  // Outputs to the pins and to Timer1 gate
  output logic [ACC_NUM-1:0] result_pin_out,
  output logic [ACC_NUM-1:0] result_pin_drive,
  output logic [ACC_NUM-1:0] result_to_timer,
  // Interrupt request toward the processor
  output logic irq_request
);

  acc_top_t s_q, s_d;

  // Synchronised compare inputs
  logic [ACC_NUM-1:0] raw_sync;
  // Per slice status, edge events and outward values
  logic [ACC_NUM-1:0] compare_result;
  logic [ACC_NUM-1:0] edge_set;
  logic [ACC_NUM-1:0] outward;
  // Divider tick and timer falling edge
  logic instr_tick;
  logic timer_clk_sel;
  logic timer_fall;
  // Write and read decode helpers
  logic do_write;
  logic [ACC_NUM-1:0] flag_clear;
  logic [7:0] wr_byte;
  logic [31:0] rd_word;
  logic rd_hit;

  // Bring asynchronous compare results into sys_clk
  acc_sync2 #(
    .W(ACC_NUM)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(core_compare_raw),
    .sync_out(raw_sync)
  );

  // Instruction cycle enable from a free divider
  assign instr_tick = (s_q.div == 2'(ACC_INSTR_DIV - 1));

  // Latch follows the prescaled clock whenever the prescaler is used
  assign timer_clk_sel = tmr1_presc_used ? tmr1_presc_clk : tmr1_src_clk;
  assign timer_fall = s_q.t1_prev & ~timer_clk_sel;

  // Two identical slices, each with its own register pair
  for (genvar i = 0; i < ACC_NUM; i++) begin : g_slice
    acc_cmp_slice u_slice (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_sync(raw_sync[i]),
      .comparator_on(s_q.ctrl0[i][ACC_C0_ON]),
      .result_invert(s_q.ctrl0[i][ACC_C0_INVERT]),
      .sync_to_timer_sel(s_q.ctrl0[i][ACC_C0_SYNC]),
      .rise_edge_irq_en(s_q.ctrl1[i][ACC_C1_RISE_EN]),
      .fall_edge_irq_en(s_q.ctrl1[i][ACC_C1_FALL_EN]),
      .instr_tick(instr_tick),
      .timer_fall(timer_fall),
      .compare_result(compare_result[i]),
      .edge_set(edge_set[i]),
      .outward(outward[i])
    );
  end

  // Positive input decode, all open while off
  function automatic logic [3:0] plus_decode(input logic on, input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    if (on) begin
      unique case (code)
        ACC_PLUS_PIN: r = 4'h1;
        ACC_PLUS_DAC: r = 4'h2;
        ACC_PLUS_FIXED: r = 4'h4;
        ACC_PLUS_GND: r = 4'h8;
      endcase
    end
    return r;
  endfunction

  // Negative input decode; reserved codes leave the node open
  function automatic logic [3:0] minus_decode(input logic on, input logic [2:0] code);
    logic [3:0] r;
    r = 4'h0;
    if (on) begin
      case (code)
        ACC_MINUS_PIN1: r = 4'h1;
        ACC_MINUS_PIN2: r = 4'h2;
        ACC_MINUS_PIN3: r = 4'h4;
        ACC_MINUS_FIXED: r = 4'h8;
        default: r = 4'h0;
      endcase
    end
    return r;
  endfunction

  // Register read mux; status bit and mirror show the sampled slice result
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr & 8'hfc)
      ACC_OFS_CTRL0_A: begin
        rd_word[7:0] = s_q.ctrl0[0];
        rd_word[ACC_C0_RESULT] = compare_result[0];
      end
      ACC_OFS_CTRL1_A: rd_word[7:0] = s_q.ctrl1[0];
      ACC_OFS_CTRL0_B: begin
        rd_word[7:0] = s_q.ctrl0[1];
        rd_word[ACC_C0_RESULT] = compare_result[1];
      end
      ACC_OFS_CTRL1_B: rd_word[7:0] = s_q.ctrl1[1];
      ACC_OFS_MIRROR: rd_word[ACC_NUM-1:0] = compare_result;
      ACC_OFS_FLAGS: rd_word[ACC_NUM-1:0] = s_q.flag;
      ACC_OFS_ENABLES: begin
        rd_word[ACC_NUM-1:0] = s_q.ie;
        rd_word[ACC_EN_GROUP] = s_q.group_en;
        rd_word[ACC_EN_GLOBAL] = s_q.global_en;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Next-state logic of divider, bus slave, registers and flags
  always_comb begin
    s_d = s_q;
    flag_clear = '0;
    wr_byte = s_q.wdata;
    // Free divider and timer clock history
    s_d.div = instr_tick ? 2'h0 : 2'(s_q.div + 2'h1);
    s_d.t1_prev = timer_clk_sel;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wbyte = s_axi_wstrb[0];
    end
    // Perform the write once both halves are held
    do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (do_write) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ACC_RESP_OKAY;
      // Only the low lane holds data; other lanes are ignored
      case (s_q.awaddr & 8'hfc)
        ACC_OFS_CTRL0_A: if (s_q.wbyte) s_d.ctrl0[0] = wr_byte & ACC_C0_WMASK;
        ACC_OFS_CTRL1_A: if (s_q.wbyte) s_d.ctrl1[0] = wr_byte & ACC_C1_WMASK;
        ACC_OFS_CTRL0_B: if (s_q.wbyte) s_d.ctrl0[1] = wr_byte & ACC_C0_WMASK;
        ACC_OFS_CTRL1_B: if (s_q.wbyte) s_d.ctrl1[1] = wr_byte & ACC_C1_WMASK;
        ACC_OFS_MIRROR: s_d.bresp = ACC_RESP_OKAY;
        // Write one to clear a flag
        ACC_OFS_FLAGS: if (s_q.wbyte) flag_clear = wr_byte[ACC_NUM-1:0];
        ACC_OFS_ENABLES: begin
          if (s_q.wbyte) begin
            s_d.ie = wr_byte[ACC_NUM-1:0];
            s_d.group_en = wr_byte[ACC_EN_GROUP];
            s_d.global_en = wr_byte[ACC_EN_GLOBAL];
          end
        end
        default: s_d.bresp = ACC_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read: one outstanding, answered the cycle after acceptance
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // Hardware only sets; a same-cycle edge beats the clear
    s_d.flag = (s_q.flag & ~flag_clear) | edge_set;
    // Request needs flag, own enable, group and global enables
    s_d.irq = (|(s_d.flag & s_d.ie)) & s_d.group_en & s_d.global_en;
  end

  // State register with control resets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      for (int i = 0; i < ACC_NUM; i++) begin
        s_q.ctrl0[i] <= ACC_C0_RESET;
        s_q.ctrl1[i] <= ACC_C1_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Bus handshakes: one held item per channel, none while answering
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Analog controls and outward paths
  always_comb begin
    for (int i = 0; i < ACC_NUM; i++) begin
      core_power_on[i] = s_q.ctrl0[i][ACC_C0_ON];
      core_speed_high[i] = s_q.ctrl0[i][ACC_C0_SPEED];
      core_hysteresis_on[i] = s_q.ctrl0[i][ACC_C0_HYST];
      plus_route[i] = plus_decode(s_q.ctrl0[i][ACC_C0_ON],
                                  s_q.ctrl1[i][ACC_C1_PLUS_LSB +: 2]);
      minus_route[i] = minus_decode(s_q.ctrl0[i][ACC_C0_ON],
                                    s_q.ctrl1[i][ACC_C1_MINUS_LSB +: 3]);
      // Pin drive ignores the enable bit; direction is kept outside
      result_pin_drive[i] = s_q.ctrl0[i][ACC_C0_PIN_DRIVE];
      result_pin_out[i] = outward[i];
      result_to_timer[i] = outward[i];
    end
  end

  assign irq_request = s_q.irq;

endmodule
`default_nettype wire

// ==== include/acc_pkg.sv ====
// Constants, register map and state types of the two-comparator control block.
// Assumes a single 25 MHz system clock and an AXI4-Lite register slave.
package acc_pkg;

  // Instance count and bus widths
  localparam int ACC_NUM = 2;
  localparam int ACC_ADDR_W = 8;

  // Instruction cycle is this many system clocks
  localparam int ACC_INSTR_DIV = 4;

  // Register byte addresses
  localparam logic [7:0] ACC_OFS_CTRL0_A = 8'h00;
  localparam logic [7:0] ACC_OFS_CTRL1_A = 8'h04;
  localparam logic [7:0] ACC_OFS_CTRL0_B = 8'h08;
  localparam logic [7:0] ACC_OFS_CTRL1_B = 8'h0c;
  localparam logic [7:0] ACC_OFS_MIRROR = 8'h10;
  localparam logic [7:0] ACC_OFS_FLAGS = 8'h14;
  localparam logic [7:0] ACC_OFS_ENABLES = 8'h18;

  // Control register 0 fields
  localparam int ACC_C0_ON = 7;
  localparam int ACC_C0_RESULT = 6;
  localparam int ACC_C0_PIN_DRIVE = 5;
  localparam int ACC_C0_INVERT = 4;
  localparam int ACC_C0_SPEED = 2;
  localparam int ACC_C0_HYST = 1;
  localparam int ACC_C0_SYNC = 0;
  localparam logic [7:0] ACC_C0_RESET = 8'h04;
  localparam logic [7:0] ACC_C0_WMASK = 8'hb7;

  // Control register 1 fields
  localparam int ACC_C1_RISE_EN = 7;
  localparam int ACC_C1_FALL_EN = 6;
  localparam int ACC_C1_PLUS_LSB = 4;
  localparam int ACC_C1_MINUS_LSB = 0;
  localparam logic [7:0] ACC_C1_RESET = 8'h00;
  localparam logic [7:0] ACC_C1_WMASK = 8'hf7;

  // Enables register fields
  localparam int ACC_EN_GROUP = 6;
  localparam int ACC_EN_GLOBAL = 7;

  // Positive input codes
  localparam logic [1:0] ACC_PLUS_PIN = 2'h0;
  localparam logic [1:0] ACC_PLUS_DAC = 2'h1;
  localparam logic [1:0] ACC_PLUS_FIXED = 2'h2;
  localparam logic [1:0] ACC_PLUS_GND = 2'h3;

  // Negative input codes, others reserved
  localparam logic [2:0] ACC_MINUS_PIN1 = 3'h1;
  localparam logic [2:0] ACC_MINUS_PIN2 = 3'h2;
  localparam logic [2:0] ACC_MINUS_PIN3 = 3'h3;
  localparam logic [2:0] ACC_MINUS_FIXED = 3'h4;

  // AXI responses
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  // State of one comparator slice
  typedef struct packed {
    logic result;
    logic prev;
    logic latched;
  } acc_slice_t;

  // State of the top block
  typedef struct packed {
    logic [ACC_NUM-1:0][7:0] ctrl0;
    logic [ACC_NUM-1:0][7:0] ctrl1;
    logic [ACC_NUM-1:0] flag;
    logic [ACC_NUM-1:0] ie;
    logic group_en;
    logic global_en;
    logic aw_have;
    logic [ACC_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wbyte;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] div;
    logic t1_prev;
    logic irq;
  } acc_top_t;

endpackage

// ==== rtl/acc_sync2.sv ====
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes one system clock; each bit is synchronised on its own.
`timescale 1ns/1ns
`default_nettype none
module acc_sync2 #(
  parameter int W = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage feeds only the second stage
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // Both stages clear on reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule
`default_nettype wire

// ==== rtl/acc_cmp_slice.sv ====
// One comparator slice: result sampling, edge detection, timer latch.
// Assumes the raw compare input is already synchronised to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module acc_cmp_slice
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic raw_sync,
  input wire logic comparator_on,
  input wire logic result_invert,
  input wire logic sync_to_timer_sel,
  input wire logic rise_edge_irq_en,
  input wire logic fall_edge_irq_en,
  input wire logic instr_tick,
  input wire logic timer_fall,
  output logic compare_result,
  output logic edge_set,
  output logic outward
);

  acc_slice_t s_q, s_d;
  // Polarity adjusted live value; off forces the core output low
  logic live;

  // Next-state logic
  always_comb begin
    live = (comparator_on & raw_sync) ^ result_invert;
    s_d = s_q;
    s_d.prev = s_q.result;
    // Internal view updates once per instruction cycle
    if (instr_tick) begin
      s_d.result = live;
    end
    // Latch only on the falling timer edge, away from the counting edge
    if (timer_fall) begin
      s_d.latched = live;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign compare_result = s_q.result;
  // Edges of the adjusted status bit, each gated by its own enable
  assign edge_set = (rise_edge_irq_en & s_q.result & ~s_q.prev) |
                    (fall_edge_irq_en & ~s_q.result & s_q.prev);
  // Direct path is deliberately unlatched; sync mode uses the latch
  assign outward = sync_to_timer_sel ? s_q.latched : live;

endmodule
`default_nettype wire

// ==== sim/acc_top_chk.sv ====
// Port-level checker for the comparator control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module acc_top_chk
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ACC_NUM-1:0] core_power_on,
  input wire logic [ACC_NUM-1:0][3:0] plus_route,
  input wire logic [ACC_NUM-1:0][3:0] minus_route,
  input wire logic [ACC_NUM-1:0] result_pin_out,
  input wire logic [ACC_NUM-1:0] result_to_timer
);
  // Everything here lives on the system clock
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A powered-down core must not load any of its inputs
  off_quiet_a: assert property (
    ({plus_route[0], minus_route[0]} & {8{!core_power_on[0]}}) == 8'h00 &&
    ({plus_route[1], minus_route[1]} & {8{!core_power_on[1]}}) == 8'h00)
    else $error("input switch closed while core is off");
  // Every positive code is valid, so a running first core has exactly one switch; while it runs, the second is held to at most one
  plus_one_a: assert property (
    core_power_on[0] |-> $onehot(plus_route[0]) && $onehot0(plus_route[1]))
    else $error("positive input switches not one-hot");
  // Reserved negative codes leave the node open, never two switches
  minus_one_a: assert property (
    $onehot0(minus_route[0]) && $onehot0(minus_route[1]))
    else $error("negative input switches overlap");
  // Pin and timer share one outward path
  outward_pair_a: assert property (
    result_to_timer == result_pin_out)
    else $error("pin and timer outputs differ");
  // No new write is taken while a response is pending
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  write_turn_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_turn_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule

bind acc_top acc_top_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .core_power_on(core_power_on), .plus_route(plus_route), .minus_route(minus_route),
  .result_pin_out(result_pin_out), .result_to_timer(result_to_timer));
`default_nettype wire

// ==== sim/acc_analog_model.sv ====
// Far side model: two analog compare cores and the Timer1 clock source.
// Assumes the bench chooses which way each compare should come out.
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int HALF_NS = 1000
) (
  input wire logic [ACC_NUM-1:0] want_high,
  input wire logic [ACC_NUM-1:0] power_on,
  output logic [ACC_NUM-1:0] core_compare_raw,
  output logic tmr1_src_clk,
  output logic tmr1_presc_clk
);
  // Timer count, only to show where the timer steps
  logic [15:0] tmr_count;
  // An unpowered core draws nothing and reports low
  assign core_compare_raw = want_high & power_on;
  // Source clock runs free, unrelated to the system clock
  initial begin
    tmr1_src_clk = 1'b0;
    tmr1_presc_clk = 1'b0;
    tmr_count = 16'h0000;
    forever #(HALF_NS) tmr1_src_clk = ~tmr1_src_clk;
  end
  // Divide-by-two prescaler; the timer steps on rising edges only
  always @(posedge tmr1_src_clk) begin
    tmr1_presc_clk <= ~tmr1_presc_clk;
    tmr_count <= tmr_count + 16'h0001;
  end
endmodule
`default_nettype wire

// ==== sim/acc_top_tb.sv ====
// Self-checking bench for the comparator control block.
// Assumes the far side model and the bound checker are compiled too.
`timescale 1ns/1ns
`default_nettype none
module acc_top_tb;
  import acc_pkg::*;
  logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tsrc, tpre, presc_used, irq;
  logic [7:0] awaddr, araddr, v;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, want, raw, pwr, spd, hys, pin, drv, tmr;
  logic [1:0][3:0] pr, mr;
  logic [7:0] en_tab [3] = '{8'h81, 8'h41, 8'hc0};
  int n_fail, checked;

  acc_top u_dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_compare_raw(raw), .tmr1_src_clk(tsrc),
    .tmr1_presc_clk(tpre), .tmr1_presc_used(presc_used), .core_power_on(pwr),
    .core_speed_high(spd), .core_hysteresis_on(hys), .plus_route(pr),
    .minus_route(mr), .result_pin_out(pin), .result_pin_drive(drv),
    .result_to_timer(tmr), .irq_request(irq));

  acc_analog_model u_far (.want_high(want), .power_on(pwr), .core_compare_raw(raw),
    .tmr1_src_clk(tsrc), .tmr1_presc_clk(tpre));

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compare, count and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bus write; entered just after a rising edge, returns the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh;
    ah = 1'b1;
    wh = 1'b1;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ah || wh) begin
      @(posedge sys_clk);
      if (ah && awready) begin
        ah = 1'b0;
        awvalid <= 1'b0;
      end
      if (wh && wready) begin
        wh = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge sys_clk);
    r = bresp;
    bready <= 1'b0;
    // Let one edge pass so a following write never re-raises bready in this step
    @(posedge sys_clk);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, resp);
    chk("bresp", 32'(ACC_RESP_OKAY), 32'(resp));
  endtask

  // Bus read; holds arvalid until taken, rready until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // One idle edge keeps rready from being assigned twice in one step
    @(posedge sys_clk);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, rv, resp);
    chk(nm, {24'h000000, e}, rv);
  endtask

  // Expected switch patterns for a running or stopped core
  function automatic logic [3:0] exp_plus(input logic on, input logic [1:0] c);
    return on ? 4'h1 << c : 4'h0;
  endfunction
  function automatic logic [3:0] exp_minus(input logic on, input logic [2:0] c);
    if (!on || c == 3'h0 || c > 3'h4) return 4'h0;
    return 4'h1 << (c - 3'h1);
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_of_test;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    want = 2'h0;
    presc_used = 1'b1;
    n_fail = 0;
    checked = 0;
    void'($urandom(50));
    rst = 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    rc("ctrl0_a", ACC_OFS_CTRL0_A, ACC_C0_RESET);
    rc("ctrl1_b", ACC_OFS_CTRL1_B, ACC_C1_RESET);
    rc("mirror_init", ACC_OFS_MIRROR, 8'h00);
    chk("speed", 32'h3, 32'(spd));
    chk("power", 32'h0, 32'(pwr));
    rd(8'h1c, rv, resp);
    chk("rresp_unmapped", 32'(ACC_RESP_SLVERR), 32'(resp));
    wr(8'h1c, 8'hff, resp);
    chk("bresp_unmapped", 32'(ACC_RESP_SLVERR), 32'(resp));
    // Second core: all writable bits, inverted result of a low compare
    w(ACC_OFS_CTRL0_B, 8'hff);
    cyc(8);
    rc("ctrl0_b", ACC_OFS_CTRL0_B, 8'hf7);
    chk("hyst", 32'h2, 32'(hys));
    w(ACC_OFS_CTRL0_B, 8'h20);
    chk("pin_drive_off", 32'h2, 32'(drv));
    // Input switches: every code at least once, then random settings
    w(ACC_OFS_CTRL0_A, 8'h80);
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? {2'h0, i[1:0], 1'b0, i[2:0]} : 8'($urandom) & 8'h37;
      w(ACC_OFS_CTRL1_A, v);
      chk("plus_route", 32'(exp_plus(1'b1, v[5:4])), 32'(pr[0]));
      chk("minus_route", 32'(exp_minus(1'b1, v[2:0])), 32'(mr[0]));
      rc("ctrl1_a", ACC_OFS_CTRL1_A, v);
    end
    w(ACC_OFS_CTRL0_A, 8'h00);
    chk("routes_off", 32'(exp_minus(1'b0, v[2:0])), 32'({pr[0], mr[0]}));
    // Edge interrupts on the first core
    w(ACC_OFS_ENABLES, 8'hc1);
    w(ACC_OFS_CTRL1_A, 8'h80);
    w(ACC_OFS_CTRL0_A, 8'h80);
    w(ACC_OFS_FLAGS, 8'h03);
    want[0] <= 1'b1;
    cyc(12);
    rc("flag_rise", ACC_OFS_FLAGS, 8'h01);
    chk("irq_on", 32'h1, 32'(irq));
    rc("mirror", ACC_OFS_MIRROR, 8'h01);
    w(ACC_OFS_FLAGS, 8'h01);
    cyc(3);
    chk("irq_clear", 32'h0, 32'(irq));
    want[0] <= 1'b0;
    cyc(12);
    rc("flag_fall_masked", ACC_OFS_FLAGS, 8'h00);
    w(ACC_OFS_CTRL1_A, 8'h40);
    w(ACC_OFS_CTRL0_A, 8'h90);
    cyc(12);
    want[0] <= 1'b1;
    cyc(12);
    rc("flag_inverted", ACC_OFS_FLAGS, 8'h01);
    w(ACC_OFS_CTRL1_A, 8'h80);
    w(ACC_OFS_FLAGS, 8'h01);
    w(ACC_OFS_CTRL0_A, 8'h10);
    cyc(12);
    rc("flag_off_toggle", ACC_OFS_FLAGS, 8'h01);
    foreach (en_tab[k]) begin
      w(ACC_OFS_ENABLES, en_tab[k]);
      cyc(3);
      chk("irq_masked", 32'h0, 32'(irq));
    end
    rc("enables", ACC_OFS_ENABLES, 8'hc0);
    w(ACC_OFS_FLAGS, 8'h01);
    // Timer synchronised output on the second core
    w(ACC_OFS_CTRL0_B, 8'h81);
    @(negedge tpre);
    cyc(6);
    for (int p = 1; p >= 0; p--) begin
      presc_used <= p[0];
      @(posedge tpre);
      @(posedge sys_clk);
      want[1] <= ~want[1];
      @(negedge tsrc);
      cyc(6);
      chk("timer_out_src", 32'h0, 32'(tmr[1]));
      chk("pin_out_src", 32'h0, 32'(pin[1]));
      @(negedge tpre);
      cyc(6);
      chk("timer_out_presc", 32'(p[0]), 32'(tmr[1]));
    end
    w(ACC_OFS_CTRL0_B, 8'h80);
    want[1] <= 1'b1;
    cyc(4);
    chk("timer_out_direct", 32'h1, 32'(tmr[1]));
    end_of_test;
  end
endmodule
`default_nettype wire
